// *** hw/codec_irq_pkg.sv ***
// Operation
// - Bus-interface resets are registered on a clock edge, then act asynchronously on their groups.
// - Bus masks, bank, device number, port state reset on every reset incl. sync loss.
// - Bus/port/general status reset on hard resets, kept across sync loss.
// - Other bus registers below split reset only on power-on or device hard reset.
// - Codec registers at or above split reset on all but sync loss.
// - Bus hard reset from bus reset, forced-reset bit, or clock-stop exit with mode set.
// - All bus-side statuses merge into one general interrupt indication.
// - Bus-side mask bit 0 blocks, 1 passes.
// - A set standard mask bit stops its event from driving the alert pin.
// - Unmasked event sets status and asserts the alert pin at once.
// - Masked event sets status but leaves the alert pin alone.
// - Alert stays asserted until all set unmasked bits have been read.
// - Status bits are sticky; clear after read once cause is gone.
// - Read while condition persists releases alert but keeps status bit.
// - Unmasking an already set status bit asserts the alert pin.
// - Inactive or normal jack alert selection: any unmasked event alerts.
// - Event-type bits clear on read unless a new event arrived.
// - Condition-type bits stay set while the condition holds.
package codec_irq_pkg;
    // Register map (word index of a 16-bit data port)
    localparam logic [7:0] ADDR_STD_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_STD_MASK    = 8'h01;
    localparam logic [7:0] ADDR_STD_KIND    = 8'h02;
    localparam logic [7:0] ADDR_MODE        = 8'h03;
    localparam logic [7:0] ADDR_BUS_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_BUS_MASK    = 8'h11;
    localparam logic [7:0] ADDR_GEN_STATUS  = 8'h12;
    localparam logic [7:0] ADDR_BUS_CTRL    = 8'h13;
    localparam logic [7:0] ADDR_BUS_CONFIG  = 8'h14;
    localparam logic [7:0] ADDR_CODEC_CFG   = 8'h20;
    // Bus control fields
    localparam int         BIT_FORCE_RESET  = 0;
    localparam int         BIT_CLKSTOP_MODE = 1;
    localparam int         BIT_BANK         = 2;
    localparam int         POS_DEVNUM       = 4;
    // Jack alert selection
    localparam logic [1:0] MODE_INACTIVE    = 2'h0;
    localparam logic [1:0] MODE_SHORT       = 2'h1;
    localparam logic [1:0] MODE_NORMAL      = 2'h3;
    // Reset values
    localparam logic [15:0] RST_STD_MASK    = 16'hffff;
    localparam logic [15:0] RST_STD_KIND    = 16'h0000;
    localparam logic [15:0] RST_BUS_MASK    = 16'h0000;
    localparam logic [15:0] RST_BUS_CTRL    = 16'h0000;
    localparam logic [15:0] RST_BUS_CONFIG  = 16'h0000;
    localparam logic [15:0] RST_CODEC_CFG   = 16'h0000;
    localparam logic [1:0]  RST_MODE        = 2'h3;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        bus_reset;
        logic        clkstop_exit;
        logic        sync_loss;
    } bus_evt_t;
endpackage

// *** hw/codec_irq_and_reset_scope.sv ***
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module codec_irq_and_reset_scope #(
    parameter int W = 16
) (
    // Clock and device resets
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       por_n_i,
    // Register port
    input  wire codec_irq_pkg::reg_req_t    req_i,
    output logic [15:0]                     rdata_o,
    // Bus events
    input  wire codec_irq_pkg::bus_evt_t    bus_evt_i,
    // Interrupt sources
    input  wire logic [W-1:0]               std_src_i,
    input  wire logic [W-1:0]               bus_src_i,
    input  wire logic                       short_det_i,
    // Outputs
    output logic                            alert_n_o,
    output logic                            bus_irq_o,
    output logic                            bus_hard_rst_o,
    output logic                            sync_rst_o
);
    // Sources: ones per cycle for events, level for conditions
    logic [W-1:0]  std_status, next_std_status;
    logic [W-1:0]  std_mask, next_std_mask;
    logic [W-1:0]  std_kind, next_std_kind;
    logic [W-1:0]  std_seen, next_std_seen;
    logic [1:0]    mode, next_mode;
    logic [W-1:0]  bus_status, next_bus_status;
    logic [W-1:0]  bus_mask, next_bus_mask;
    logic          gen_status, next_gen_status;
    logic [15:0]   bus_ctrl, next_bus_ctrl;
    logic [15:0]   bus_config, next_bus_config;
    logic [15:0]   codec_cfg, next_codec_cfg;
    logic [15:0]   next_rdata;
    logic          hard_req;
    logic          hard_rst_n;
    logic          all_rst_n;
    logic          sync_hold;

    function automatic logic hit(input logic [7:0] a);
        hit = req_i.rd && (req_i.addr == a);
    endfunction

    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = req_i.wr && (req_i.addr == a);
    endfunction

    // Hard reset request; one cycle pulse registered to stay glitch free
    always_comb begin
        hard_req = bus_evt_i.bus_reset
                 | bus_ctrl[codec_irq_pkg::BIT_FORCE_RESET]
                 | (bus_evt_i.clkstop_exit & bus_ctrl[codec_irq_pkg::BIT_CLKSTOP_MODE]);
    end

    logic hard_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hard_q    <= 1'b0;
            sync_hold <= 1'b0;
        end else begin
            hard_q    <= hard_req;
            sync_hold <= bus_evt_i.sync_loss;
        end
    end

    // Derived resets act asynchronously on their register groups
    assign hard_rst_n = rst_n_i & por_n_i & ~hard_q;
    assign all_rst_n  = hard_rst_n & ~sync_hold;
    assign bus_hard_rst_o = hard_q;
    assign sync_rst_o     = sync_hold;

    // Standard status: set wins over read clear
    always_comb begin
        next_std_status = std_status;
        next_std_seen   = std_seen;
        for (int i = 0; i < W; i++) begin
            if (hit(codec_irq_pkg::ADDR_STD_STATUS)) begin
                next_std_seen[i] = std_status[i];
                if (!std_src_i[i]) begin
                    next_std_status[i] = 1'b0;
                end
            end
            if (std_src_i[i]) begin
                next_std_status[i] = 1'b1;
                if (!std_status[i] || !std_kind[i]) begin
                    next_std_seen[i] = 1'b0;
                end
            end
            if (!next_std_status[i]) begin
                next_std_seen[i] = 1'b0;
            end
        end
        // Read releases the alert even when a condition keeps the bit set
        if (hit(codec_irq_pkg::ADDR_STD_STATUS)) begin
            next_std_seen = std_status | (std_seen & std_src_i & std_kind);
        end
    end

    // Codec registers above split: hard resets only
    always_comb begin
        next_std_mask  = std_mask;
        next_std_kind  = std_kind;
        next_mode      = mode;
        next_codec_cfg = codec_cfg;
        if (wr_hit(codec_irq_pkg::ADDR_STD_MASK)) begin
            next_std_mask = req_i.wdata[W-1:0];
        end
        if (wr_hit(codec_irq_pkg::ADDR_STD_KIND)) begin
            next_std_kind = req_i.wdata[W-1:0];
        end
        if (wr_hit(codec_irq_pkg::ADDR_MODE)) begin
            next_mode = req_i.wdata[1:0];
        end
        if (wr_hit(codec_irq_pkg::ADDR_CODEC_CFG)) begin
            next_codec_cfg = req_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i or negedge hard_rst_n) begin
        if (!hard_rst_n) begin
            std_status <= '0;
            std_seen   <= '0;
            std_mask   <= codec_irq_pkg::RST_STD_MASK[W-1:0];
            std_kind   <= codec_irq_pkg::RST_STD_KIND[W-1:0];
            mode       <= codec_irq_pkg::RST_MODE;
            codec_cfg  <= codec_irq_pkg::RST_CODEC_CFG;
        end else begin
            std_status <= next_std_status;
            std_seen   <= next_std_seen;
            std_mask   <= next_std_mask;
            std_kind   <= next_std_kind;
            mode       <= next_mode;
            codec_cfg  <= next_codec_cfg;
        end
    end

    // Bus status group: hard resets, kept on sync loss
    always_comb begin
        next_bus_status = bus_status | bus_src_i;
        if (hit(codec_irq_pkg::ADDR_BUS_STATUS)) begin
            next_bus_status = bus_src_i;
        end
        next_gen_status = |(next_bus_status & bus_mask);
    end

    always_ff @(posedge clk_sys_i or negedge hard_rst_n) begin
        if (!hard_rst_n) begin
            bus_status <= '0;
            gen_status <= 1'b0;
        end else begin
            bus_status <= next_bus_status;
            gen_status <= next_gen_status;
        end
    end

    // Masks, bank, device number: every reset including sync loss
    always_comb begin
        next_bus_mask = bus_mask;
        next_bus_ctrl = bus_ctrl;
        next_bus_ctrl[codec_irq_pkg::BIT_FORCE_RESET] = 1'b0;
        if (wr_hit(codec_irq_pkg::ADDR_BUS_MASK)) begin
            next_bus_mask = req_i.wdata[W-1:0];
        end
        if (wr_hit(codec_irq_pkg::ADDR_BUS_CTRL)) begin
            next_bus_ctrl = req_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i or negedge all_rst_n) begin
        if (!all_rst_n) begin
            bus_mask <= codec_irq_pkg::RST_BUS_MASK[W-1:0];
            bus_ctrl <= codec_irq_pkg::RST_BUS_CTRL;
        end else begin
            bus_mask <= next_bus_mask;
            bus_ctrl <= next_bus_ctrl;
        end
    end

    // Other bus registers: device resets only
    always_comb begin
        next_bus_config = bus_config;
        if (wr_hit(codec_irq_pkg::ADDR_BUS_CONFIG)) begin
            next_bus_config = req_i.wdata;
        end
    end

    logic dev_rst_n;
    assign dev_rst_n = rst_n_i & por_n_i;

    always_ff @(posedge clk_sys_i or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            bus_config <= codec_irq_pkg::RST_BUS_CONFIG;
        end else begin
            bus_config <= next_bus_config;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_comb begin
        next_rdata = 16'h0000;
        if (req_i.rd) begin
            case (req_i.addr)
                codec_irq_pkg::ADDR_STD_STATUS: next_rdata[W-1:0] = std_status;
                codec_irq_pkg::ADDR_STD_MASK:   next_rdata[W-1:0] = std_mask;
                codec_irq_pkg::ADDR_STD_KIND:   next_rdata[W-1:0] = std_kind;
                codec_irq_pkg::ADDR_MODE:       next_rdata[1:0]   = mode;
                codec_irq_pkg::ADDR_BUS_STATUS: next_rdata[W-1:0] = bus_status;
                codec_irq_pkg::ADDR_BUS_MASK:   next_rdata[W-1:0] = bus_mask;
                codec_irq_pkg::ADDR_GEN_STATUS: next_rdata[0]     = gen_status;
                codec_irq_pkg::ADDR_BUS_CTRL:   next_rdata        = bus_ctrl;
                codec_irq_pkg::ADDR_BUS_CONFIG: next_rdata        = bus_config;
                codec_irq_pkg::ADDR_CODEC_CFG:  next_rdata        = codec_cfg;
                default:                        next_rdata        = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // Alert: combinational so a new event or unmask shows at once
    logic std_pend;
    always_comb begin
        std_pend = |(std_status & ~std_seen & ~std_mask);
        if (mode == codec_irq_pkg::MODE_SHORT) begin
            alert_n_o = ~short_det_i;
        end else begin
            // Read bits drop out, else a held condition pins the alert low
            alert_n_o = ~(std_pend | |(std_src_i & ~std_mask & ~std_seen));
        end
    end

    assign bus_irq_o = gen_status;
endmodule
`default_nettype wire

// *** bench/codec_irq_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module codec_irq_props #(
    parameter int W = 16
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    por_n_i,
    input  wire codec_irq_pkg::reg_req_t req_i,
    input  wire logic [15:0]             rdata_o,
    input  wire codec_irq_pkg::bus_evt_t bus_evt_i,
    input  wire logic [W-1:0]            std_src_i,
    input  wire logic [W-1:0]            bus_src_i,
    input  wire logic                    short_det_i,
    input  wire logic                    alert_n_o,
    input  wire logic                    bus_irq_o,
    input  wire logic                    bus_hard_rst_o,
    input  wire logic                    sync_rst_o
);
    // Shadow copies lag the design's async resets; a_new_event_alert and a_bus_blocked trust them only when settled
    logic [W-1:0] mask, bmask, next_mask, next_bmask;
    logic [1:0]   mode, ctrl, next_mode, next_ctrl;
    logic         rst_any_n;
    assign rst_any_n = rst_n_i & por_n_i;
    always_comb begin
        next_mask  = mask;
        next_bmask = bmask;
        next_mode  = mode;
        next_ctrl  = ctrl;
        if (req_i.wr && req_i.addr == codec_irq_pkg::ADDR_STD_MASK) next_mask = req_i.wdata[W-1:0];
        if (req_i.wr && req_i.addr == codec_irq_pkg::ADDR_BUS_MASK) next_bmask = req_i.wdata[W-1:0];
        if (req_i.wr && req_i.addr == codec_irq_pkg::ADDR_MODE) next_mode = req_i.wdata[1:0];
        if (req_i.wr && req_i.addr == codec_irq_pkg::ADDR_BUS_CTRL) next_ctrl = req_i.wdata[1:0];
        if (bus_hard_rst_o) begin
            next_mask = codec_irq_pkg::RST_STD_MASK[W-1:0];
            next_mode = codec_irq_pkg::RST_MODE;
        end
        if (bus_hard_rst_o || sync_rst_o) begin
            next_bmask = '0;
            next_ctrl  = 2'h0;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_any_n) begin
        if (!rst_any_n) begin
            mask  <= codec_irq_pkg::RST_STD_MASK[W-1:0];
            bmask <= '0;
            mode  <= codec_irq_pkg::RST_MODE;
            ctrl  <= 2'h0;
        end else begin
            mask  <= next_mask;
            bmask <= next_bmask;
            mode  <= next_mode;
            ctrl  <= next_ctrl;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_any_n);
    a_short_alert: assert property (mode == codec_irq_pkg::MODE_SHORT |-> alert_n_o == !short_det_i)
        else $error("alert pin not following short detect");
    a_new_event_alert: assert property (mode != codec_irq_pkg::MODE_SHORT && !bus_hard_rst_o
        && (std_src_i & ~$past(std_src_i) & ~mask) != '0 |-> !alert_n_o)
        else $error("unmasked event did not assert alert");
    a_read_idle: assert property (!req_i.rd |=> rdata_o == 16'h0)
        else $error("read data outside read cycle");
    a_sync_copy: assert property (1'b1 |=> sync_rst_o == $past(bus_evt_i.sync_loss))
        else $error("sync reset does not follow sync loss");
    a_hard_bus: assert property (bus_evt_i.bus_reset |=> bus_hard_rst_o)
        else $error("bus reset gave no hard reset");
    a_hard_clkstop: assert property (bus_evt_i.clkstop_exit && ctrl[codec_irq_pkg::BIT_CLKSTOP_MODE] |=> bus_hard_rst_o)
        else $error("clock stop exit gave no hard reset");
    a_hard_force: assert property (req_i.wr && req_i.addr == codec_irq_pkg::ADDR_BUS_CTRL
        && req_i.wdata[codec_irq_pkg::BIT_FORCE_RESET] |-> ##[1:2] bus_hard_rst_o)
        else $error("forced reset gave no hard reset");
    a_bus_blocked: assert property ((bmask == '0)[*3] |-> !bus_irq_o)
        else $error("bus interrupt passed a cleared mask");
    a_bus_pass: assert property ((bus_src_i & bmask) != '0 && !sync_rst_o |-> ##[1:3] bus_irq_o)
        else $error("unmasked bus source gave no interrupt");
endmodule
bind codec_irq_and_reset_scope codec_irq_props #(.W(W)) props_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .por_n_i(por_n_i), .req_i(req_i), .rdata_o(rdata_o), .bus_evt_i(bus_evt_i), .std_src_i(std_src_i),
    .bus_src_i(bus_src_i), .short_det_i(short_det_i), .alert_n_o(alert_n_o), .bus_irq_o(bus_irq_o),
    .bus_hard_rst_o(bus_hard_rst_o), .sync_rst_o(sync_rst_o));
`default_nettype wire

// *** bench/codec_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module codec_host_model (
    // Clock
    input  wire logic                    clk_sys_i,
    // Register port
    input  wire logic [15:0]             rdata_i,
    output var  codec_irq_pkg::reg_req_t req_o
);
    initial req_o = '0;
    // Released bus shows the inverse, so a stale address never passes
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys_i);
        req_o <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        req_o <= '{addr: ~a, wdata: ~v, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys_i);
        req_o <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        req_o <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
        #1 v = rdata_i;
    endtask
endmodule
`default_nettype wire

// *** bench/codec_irq_and_reset_scope_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module codec_irq_and_reset_scope_tb;
    logic                    clk_sys_i = 1'b0;
    logic                    rst_n_i = 1'b0;
    logic                    por_n_i = 1'b0;
    logic [15:0]             src = '0, bsrc = '0, d, rdata;
    logic                    short_det = 1'b0, alert_n, bus_irq, hard, sync_rst;
    codec_irq_pkg::bus_evt_t evt = '0;
    codec_irq_pkg::reg_req_t req;
    int                      failures = 0, n_compared = 0, cyc = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    codec_host_model host_u (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .req_o(req));
    codec_irq_and_reset_scope #(.W(16)) dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
        .req_i(req), .rdata_o(rdata), .bus_evt_i(evt), .std_src_i(src), .bus_src_i(bsrc),
        .short_det_i(short_det), .alert_n_o(alert_n), .bus_irq_o(bus_irq), .bus_hard_rst_o(hard),
        .sync_rst_o(sync_rst));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        host_u.rd(a, d);
        chk(d, exp);
    endtask
    task automatic ev(input int i, input logic exp);
        @(posedge clk_sys_i);
        src <= 16'h1 << i;
        #1 chk({15'h0, alert_n}, {15'h0, exp});
        @(posedge clk_sys_i);
        src <= '0;
    endtask
    task automatic bus_pulse;
        @(posedge clk_sys_i);
        bsrc <= 16'h1;
        @(posedge clk_sys_i);
        bsrc <= '0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            complete_run();
        end
    end
    task automatic t_events;
        rd(codec_irq_pkg::ADDR_STD_MASK, codec_irq_pkg::RST_STD_MASK);
        host_u.wr(8'h7f, 16'h1234);
        rd(8'h7f, 16'h0000);
        host_u.wr(codec_irq_pkg::ADDR_STD_MASK, 16'hfffe);
        ev(1, 1'b1);
        ev(0, 1'b0);
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0003);
        chk({15'h0, alert_n}, 16'h0001);
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0000);
        ev(1, 1'b1);
        host_u.wr(codec_irq_pkg::ADDR_STD_MASK, 16'hfffc);
        #1 chk({15'h0, alert_n}, 16'h0000);
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0002);
        host_u.wr(codec_irq_pkg::ADDR_STD_KIND, 16'h0004);
        host_u.wr(codec_irq_pkg::ADDR_STD_MASK, 16'hfffb);
        @(posedge clk_sys_i);
        src <= 16'h0004;
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0004);
        chk({15'h0, alert_n}, 16'h0001);
        @(posedge clk_sys_i);
        src <= '0;
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0004);
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0000);
        $display("status and mask test done");
    endtask
    task automatic t_short;
        host_u.wr(codec_irq_pkg::ADDR_STD_MASK, 16'h0000);
        host_u.wr(codec_irq_pkg::ADDR_MODE, {14'h0, codec_irq_pkg::MODE_SHORT});
        ev(3, 1'b1);
        @(posedge clk_sys_i);
        short_det <= 1'b1;
        #1 chk({15'h0, alert_n}, 16'h0000);
        @(posedge clk_sys_i);
        short_det <= 1'b0;
        rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0008);
        for (int k = 0; k < 2; k++) begin
            host_u.wr(codec_irq_pkg::ADDR_MODE, {14'h0, k ? codec_irq_pkg::MODE_NORMAL : codec_irq_pkg::MODE_INACTIVE});
            #1 chk({15'h0, alert_n}, 16'h0001);
            ev(5, 1'b0);
            rd(codec_irq_pkg::ADDR_STD_STATUS, 16'h0020);
        end
        $display("alert mode test done");
    endtask
    task automatic t_bus;
        bus_pulse();
        chk({15'h0, bus_irq}, 16'h0000);
        host_u.rd(codec_irq_pkg::ADDR_BUS_STATUS, d);
        host_u.wr(codec_irq_pkg::ADDR_BUS_MASK, 16'h0001);
        bus_pulse();
        chk({15'h0, bus_irq}, 16'h0001);
        rd(codec_irq_pkg::ADDR_GEN_STATUS, 16'h0001);
        rd(codec_irq_pkg::ADDR_BUS_STATUS, 16'h0001);
        $display("bus interrupt test done");
    endtask
    task automatic t_resets;
        host_u.wr(codec_irq_pkg::ADDR_BUS_CONFIG, 16'h00a5);
        host_u.wr(codec_irq_pkg::ADDR_CODEC_CFG, 16'h005a);
        host_u.wr(codec_irq_pkg::ADDR_BUS_CTRL, 16'h0004);
        bus_pulse();
        @(posedge clk_sys_i);
        evt.sync_loss <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        evt.sync_loss <= 1'b0;
        rd(codec_irq_pkg::ADDR_BUS_MASK, 16'h0000);
        rd(codec_irq_pkg::ADDR_BUS_CTRL, 16'h0000);
        rd(codec_irq_pkg::ADDR_BUS_STATUS, 16'h0001);
        rd(codec_irq_pkg::ADDR_CODEC_CFG, 16'h005a);
        rd(codec_irq_pkg::ADDR_BUS_CONFIG, 16'h00a5);
        host_u.wr(codec_irq_pkg::ADDR_BUS_MASK, 16'h0001);
        bus_pulse();
        @(posedge clk_sys_i);
        evt.bus_reset <= 1'b1;
        @(posedge clk_sys_i);
        evt.bus_reset <= 1'b0;
        #1 chk({15'h0, hard}, 16'h0001);
        rd(codec_irq_pkg::ADDR_BUS_STATUS, 16'h0000);
        rd(codec_irq_pkg::ADDR_CODEC_CFG, 16'h0000);
        rd(codec_irq_pkg::ADDR_STD_MASK, codec_irq_pkg::RST_STD_MASK);
        rd(codec_irq_pkg::ADDR_BUS_CONFIG, 16'h00a5);
        host_u.wr(codec_irq_pkg::ADDR_BUS_CTRL, 16'h0002);
        @(posedge clk_sys_i);
        evt.clkstop_exit <= 1'b1;
        @(posedge clk_sys_i);
        evt.clkstop_exit <= 1'b0;
        #1 chk({15'h0, hard}, 16'h0001);
        host_u.wr(codec_irq_pkg::ADDR_BUS_CTRL, 16'h0001);
        @(posedge clk_sys_i);
        #1 chk({15'h0, hard}, 16'h0001);
        host_u.wr(codec_irq_pkg::ADDR_STD_MASK, 16'hfffe);
        ev(0, 1'b0);
        #2 rst_n_i = 1'b0;
        #1 chk({15'h0, alert_n}, 16'h0001);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(codec_irq_pkg::ADDR_BUS_CONFIG, 16'h0000);
        $display("reset scope test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        t_events();
        t_short();
        t_bus();
        t_resets();
        complete_run();
    end
endmodule
`default_nettype wire
